// ### hdl/gpb_pin_banks.sv
// five pin banks with output latches and write-only direction registers
//
// Overview of operation
// - bank reads return live pin levels, or the stored byte on storage banks
// - every reset sets all direction bits one
// - bank A has four low pins, upper zero
// - bank B has all eight pins
// - bank C pins on mid/large, else storage
// - bank D pins on large only, else storage
// - bank E high nibble pins on large only
// - direction load copies working register value
// - direction one tristates, zero drives latch
// - direction registers have no read path
// - output latch holds until next write
// - each pin has its own direction bit
// - latches undefined at power-on, kept otherwise
// - bit set/clear read pins, write whole latch
// - write ends cycle, read samples at the closing edge too
`timescale 1ns/1ps
`default_nettype none
`include "gpb_params.svh"

module gpb_pin_banks
#(
    parameter logic [1:0] VARIANT = `GPB_VAR_LARGE  // 0 small, 1 mid, 2 large
)
(
    input  wire logic               clock_i,     // instruction-cycle clock
    input  wire logic               rst_i,       // any reset, sync high
    input  wire logic [7:0]         addr_i,      // file address of access
    input  wire gpb_pkg::gpb_op_t   op_i,        // write / bit set / clear
    input  wire logic [2:0]         bit_sel_i,   // bit for set or clear
    input  wire logic [7:0]         wdata_i,     // data for plain write
    input  wire logic               rd_i,        // read strobe
    input  wire logic               dir_ld_i,    // direction-load strobe
    input  wire logic [7:0]         wreg_i,      // working register value
    input  wire logic [39:0]        pin_in_i,    // pin levels, bank a at lsb
    output logic [39:0]             pin_out_o,   // pin drive values
    output logic [39:0]             pin_oe_o,    // pin drive enables
    output logic [7:0]              rdata_o,     // read data
    output logic                    rvalid_o     // read data valid pulse
);
    import gpb_pkg::*;

    gpb_state_t s_q;
    gpb_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // decoding used by read and write paths

    // pins that exist in a bank for this variant
    function automatic logic [7:0] pin_mask(input int b);
        logic [7:0] m;
        m = `GPB_MASK_NONE;
        case (b)
            0: m = `GPB_MASK_A;
            1: m = `GPB_MASK_FULL;
            2: m = (VARIANT != `GPB_VAR_SMALL) ?
                   `GPB_MASK_FULL : `GPB_MASK_NONE;
            3: m = (VARIANT == `GPB_VAR_LARGE) ?
                   `GPB_MASK_FULL : `GPB_MASK_NONE;
            4: m = (VARIANT == `GPB_VAR_LARGE) ?
                   `GPB_MASK_E : `GPB_MASK_NONE;
            default: m = `GPB_MASK_NONE;
        endcase
        return m;
    endfunction

    // a bank with no pins becomes a plain storage byte
    function automatic logic is_storage(input int b);
        return pin_mask(b) == `GPB_MASK_NONE;
    endfunction

    // bank index of an address, or the bank count when unmapped
    function automatic int bank_of(input logic [7:0] a);
        int r;
        r = `GPB_NUM_BANKS;
        case (a)
            `GPB_ADDR_BANK_A: r = 0;
            `GPB_ADDR_BANK_B: r = 1;
            `GPB_ADDR_BANK_C: r = 2;
            `GPB_ADDR_BANK_D: r = 3;
            `GPB_ADDR_BANK_E: r = 4;
            default:          r = `GPB_NUM_BANKS;
        endcase
        return r;
    endfunction

    // value a read of bank b returns: pins, or stored byte for storage
    function automatic logic [7:0] read_val(input int b,
                                            input logic [7:0] lat);
        logic [7:0] v;
        v = `GPB_MASK_NONE;
        if (b < `GPB_NUM_BANKS)
        begin
            if (is_storage(b))
                v = lat;
            else
                v = pin_in_i[b*8 +: 8] & pin_mask(b);
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next-state logic

    // pins are sampled combinationally in the access cycle and results
    // land at its closing edge; external levels must be stable then
    always_comb
    begin
        int         b;
        logic [7:0] cur;
        b      = bank_of(addr_i);
        cur    = `GPB_MASK_NONE;
        s_d    = s_q;
        s_d.rvalid = 1'b0;
        if (b < `GPB_NUM_BANKS)
        begin
            cur = read_val(b, s_q.latch[b]);
            // read path never looks at direction state
            if (rd_i)
            begin
                s_d.rdata  = cur;
                s_d.rvalid = 1'b1;
            end
            // latch written regardless of direction
            case (op_i)
                GPB_OP_WRITE: s_d.latch[b] = wdata_i;
                GPB_OP_BSET:
                begin
                    cur[bit_sel_i] = 1'b1;
                    s_d.latch[b]   = cur;
                end
                GPB_OP_BCLR:
                begin
                    cur[bit_sel_i] = 1'b0;
                    s_d.latch[b]   = cur;
                end
                default: s_d.latch[b] = s_q.latch[b];
            endcase
            if (dir_ld_i && !is_storage(b))
                s_d.dir[b] = wreg_i;
        end
        // reset sets direction and clears read data; latches keep content
        if (rst_i)
        begin
            for (int i = 0; i < `GPB_NUM_BANKS; i++)
                s_d.dir[i] = `GPB_DIR_RESET;
            s_d.rdata  = `GPB_MASK_NONE;
            s_d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; latches are left without reset on purpose

    always_ff @(posedge clock_i)
    begin
        s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, one per pin, registered outputs

    logic [39:0] drv_q;
    logic [39:0] oe_q;

    genvar g;
    generate
        for (g = 0; g < 40; g++)
        begin : g_pin
            // pins missing in this variant never get an enable; the mask
            // is fixed at elaboration so no decode logic is spent on it
            localparam logic [7:0] BMASK = pin_mask(g / 8);
            // each pin has its own enable from its own bit
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                begin
                    oe_q[g]  <= 1'b0;
                    drv_q[g] <= 1'b0;
                end
                else
                begin
                    oe_q[g]  <= ~s_d.dir[g/8][g%8]
                                & BMASK[g%8];
                    drv_q[g] <= s_d.latch[g/8][g%8];
                end
            end
        end
    endgenerate

    assign pin_out_o = drv_q;
    assign pin_oe_o  = oe_q;
    assign rdata_o   = s_q.rdata;
    assign rvalid_o  = s_q.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_RST_TRI: assert property (@(posedge clock_i)
        rst_i |=> (pin_oe_o == 40'h0) && (s_q.dir[1] == `GPB_DIR_RESET))
        else $error("pins not tristated after reset");

    AST_READ_PINS: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_i && bank_of(addr_i) == 1
        |=> rvalid_o && rdata_o == $past(pin_in_i[15:8]))
        else $error("bank b read not pin levels");

    AST_A_HIGH_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_i && addr_i == `GPB_ADDR_BANK_A |=> rdata_o[7:4] == 4'h0)
        else $error("bank a high nibble not zero");

    AST_DIR_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
        dir_ld_i && addr_i == `GPB_ADDR_BANK_B
        |=> s_q.dir[1] == $past(wreg_i) ##1 pin_oe_o[15:8] == ~s_q.dir[1])
        else $error("direction load wrong");

    AST_HOLD: assert property (@(posedge clock_i)
        op_i == GPB_OP_NONE |=> $stable(s_q.latch))
        else $error("latch changed without write");

    AST_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        pin_oe_o[8] |-> pin_out_o[8] == s_q.latch[1][0])
        else $error("driven pin not latch value");

    AST_BSET: assert property (@(posedge clock_i) disable iff (rst_i)
        op_i == GPB_OP_BSET && addr_i == `GPB_ADDR_BANK_B
        |=> s_q.latch[1] == ($past(pin_in_i[15:8])
                             | (8'h01 << $past(bit_sel_i))))
        else $error("bit set not read-modify-write");

    AST_E_ABSENT: assert property (@(posedge clock_i)
        VARIANT != `GPB_VAR_LARGE |-> pin_oe_o[39:24] == 16'h0)
        else $error("absent bank driven");

    ////////////////////////////////////////////////////////////////////////
    // reset and direction checks; the latches stay out of these because
    // they hold unknown content until software first writes them

    // every bank, not only bank b, comes out of reset as inputs
    AST_DIR_ALL_RST: assert property (@(posedge clock_i)
        rst_i |=> s_q.dir == {5{`GPB_DIR_RESET}})
        else $error("direction not all ones after reset");

    // bank b enables follow their own direction bits one by one
    AST_OE_PER_PIN: assert property (@(posedge clock_i) disable iff (rst_i)
        1'b1 |-> pin_oe_o[15:8] == ~s_q.dir[1])
        else $error("bank b enable not per pin");

    // bank e high nibble follows a direction load on the large part
    AST_DIR_LOAD_E: assert property (@(posedge clock_i) disable iff (rst_i)
        VARIANT == `GPB_VAR_LARGE && dir_ld_i
        && addr_i == `GPB_ADDR_BANK_E
        |=> pin_oe_o[39:36] == ~$past(wreg_i[7:4]))
        else $error("bank e direction load wrong");

    // a storage byte has no direction register to load
    AST_DIR_STORAGE: assert property (@(posedge clock_i) disable iff (rst_i)
        VARIANT == `GPB_VAR_SMALL && dir_ld_i
        && addr_i == `GPB_ADDR_BANK_C |=> $stable(s_q.dir[2]))
        else $error("storage byte took a direction");

    // unimplemented bit positions never drive
    AST_A_HIGH_NO_OE: assert property (@(posedge clock_i)
        1'b1 |-> pin_oe_o[7:4] == 4'h0)
        else $error("bank a high nibble driven");

    AST_E_LOW_NO_OE: assert property (@(posedge clock_i)
        1'b1 |-> pin_oe_o[35:32] == 4'h0)
        else $error("bank e low nibble driven");

    AST_C_SMALL_NO_OE: assert property (@(posedge clock_i)
        VARIANT == `GPB_VAR_SMALL |-> pin_oe_o[23:16] == 8'h0)
        else $error("storage bank c driven");

    AST_D_NO_OE: assert property (@(posedge clock_i)
        VARIANT != `GPB_VAR_LARGE |-> pin_oe_o[31:24] == 8'h0)
        else $error("storage bank d driven");

    ////////////////////////////////////////////////////////////////////////
    // read and latch checks

    // bank a reads pins, masked to its four implemented bits
    AST_READ_A: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_i && addr_i == `GPB_ADDR_BANK_A
        |=> rdata_o == ($past(pin_in_i[7:0]) & `GPB_MASK_A))
        else $error("bank a read not pin levels");

    // bank e low nibble reads zero on the large part
    AST_E_LOW_ZERO: assert property (@(posedge clock_i) disable iff (rst_i)
        VARIANT == `GPB_VAR_LARGE && rd_i && addr_i == `GPB_ADDR_BANK_E
        |=> rdata_o[3:0] == 4'h0)
        else $error("bank e low nibble not zero");

    // on the small part bank c reads back the stored byte
    AST_STORAGE_C: assert property (@(posedge clock_i) disable iff (rst_i)
        VARIANT == `GPB_VAR_SMALL && rd_i && addr_i == `GPB_ADDR_BANK_C
        |=> rdata_o == $past(s_q.latch[2]))
        else $error("storage byte read wrong");

    // unmapped addresses give no read answer
    AST_UNMAPPED: assert property (@(posedge clock_i) disable iff (rst_i)
        rd_i && bank_of(addr_i) == `GPB_NUM_BANKS |=> !rvalid_o)
        else $error("unmapped read answered");

    // valid is a single pulse that only a read request raises
    AST_RVALID_PULSE: assert property (@(posedge clock_i)
        !rd_i |=> !rvalid_o)
        else $error("read valid without request");

    // read data stands until the next read
    AST_RDATA_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
        !rd_i |=> $stable(rdata_o))
        else $error("read data changed without read");

    // plain write lands whatever the direction is
    AST_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
        op_i == GPB_OP_WRITE && addr_i == `GPB_ADDR_BANK_B
        |=> s_q.latch[1] == $past(wdata_i))
        else $error("latch write not taken");

    // bit clear also writes back every other pin level
    AST_BCLR: assert property (@(posedge clock_i) disable iff (rst_i)
        op_i == GPB_OP_BCLR && addr_i == `GPB_ADDR_BANK_B
        |=> s_q.latch[1] == ($past(pin_in_i[15:8])
                             & ~(8'h01 << $past(bit_sel_i))))
        else $error("bit clear not read-modify-write");

    // a driven bank b top pin shows its latch bit
    AST_DRIVE_B: assert property (@(posedge clock_i) disable iff (rst_i)
        pin_oe_o[15] |-> pin_out_o[15] == s_q.latch[1][7])
        else $error("driven top pin not latch value");

endmodule
`default_nettype wire

// ### hdl/gpb_params.svh
// constants for the bidirectional pin bank block
`ifndef GPB_PARAMS_SVH
`define GPB_PARAMS_SVH

`define GPB_ADDR_BANK_A  8'h05
`define GPB_ADDR_BANK_B  8'h06
`define GPB_ADDR_BANK_C  8'h07
`define GPB_ADDR_BANK_D  8'h08
`define GPB_ADDR_BANK_E  8'h09
`define GPB_DIR_RESET    8'hff
`define GPB_MASK_A       8'h0f
`define GPB_MASK_FULL    8'hff
`define GPB_MASK_E       8'hf0
`define GPB_MASK_NONE    8'h00
`define GPB_NUM_BANKS    5
`define GPB_VAR_SMALL    2'h0
`define GPB_VAR_MID      2'h1
`define GPB_VAR_LARGE    2'h2

`endif

// ### hdl/gpb_pkg.sv
// types for the bidirectional pin bank block
package gpb_pkg;

    // bank access operation requested by the core
    typedef enum logic [1:0]
    {
        GPB_OP_NONE  = 2'h0,
        GPB_OP_WRITE = 2'h1,
        GPB_OP_BSET  = 2'h2,
        GPB_OP_BCLR  = 2'h3
    } gpb_op_t;

    // registered state of the block, apart from the pin driver flops
    typedef struct packed
    {
        logic [4:0][7:0] latch;
        logic [4:0][7:0] dir;
        logic [7:0]      rdata;
        logic            rvalid;
    } gpb_state_t;

endpackage

// ### tb/gpb_ext_model.sv
// external circuitry that sits on the pins of all five banks
`timescale 1ns/1ps
`default_nettype none

module gpb_ext_model
(
    input  wire logic [39:0] pin_out_i,  // drive values from the block
    input  wire logic [39:0] pin_oe_i,   // drive enables from the block
    input  wire logic [39:0] ext_val_i,  // level the outside drives
    input  wire logic [39:0] ext_en_i,   // outside drives this pin
    output wire logic [39:0] pin_lvl_o   // resolved pin level
);
    ////////////////////////////////////////////////////////////////////////
    // block driver wins; the outside holds its level until it is changed,
    // and a pin driven by nobody floats up to its pull-up
    assign pin_lvl_o = (pin_oe_i & pin_out_i)
                     | (~pin_oe_i & ext_en_i & ext_val_i)
                     | (~pin_oe_i & ~ext_en_i);
endmodule

`default_nettype wire

// ### tb/gpb_pin_banks_tb.sv
// self-checking bench for the pin bank block
`timescale 1ns/1ps
`default_nettype none

module gpb_pin_banks_tb;
    import gpb_pkg::*;
    logic        clock_i, rst_i, rd, dld, rv, rv_s;
    logic [7:0]  addr, wdata, rdata, rdata_s;
    logic [2:0]  bsel;
    gpb_op_t     op;
    logic [39:0] lvl, pout, poe, pout_s, poe_s, xval, xen;
    int          n_fail, n_compared;

    ////////////////////////////////////////////////////////////////////////
    // large variant under test, small variant beside it on the same inputs
    gpb_pin_banks #(.VARIANT(2'h2)) u_gpb_pin_banks (.clock_i(clock_i),
        .rst_i(rst_i), .addr_i(addr), .op_i(op), .bit_sel_i(bsel),
        .wdata_i(wdata), .rd_i(rd), .dir_ld_i(dld), .wreg_i(wdata),
        .pin_in_i(lvl), .pin_out_o(pout), .pin_oe_o(poe),
        .rdata_o(rdata), .rvalid_o(rv));
    gpb_pin_banks #(.VARIANT(2'h0)) u_gpb_pin_banks_s (.clock_i(clock_i),
        .rst_i(rst_i), .addr_i(addr), .op_i(op), .bit_sel_i(bsel),
        .wdata_i(wdata), .rd_i(rd), .dir_ld_i(dld), .wreg_i(wdata),
        .pin_in_i(lvl), .pin_out_o(pout_s), .pin_oe_o(poe_s),
        .rdata_o(rdata_s), .rvalid_o(rv_s));
    gpb_ext_model u_gpb_ext_model (.pin_out_i(pout), .pin_oe_i(poe),
        .ext_val_i(xval), .ext_en_i(xen), .pin_lvl_o(lvl));

    ////////////////////////////////////////////////////////////////////////
    // comparison, one access cycle, and the closing report
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // request stands for one cycle; #1 lets the answering edge land
    task automatic cyc(input logic [7:0] a, input gpb_op_t o,
                       input logic [2:0] b, input logic [7:0] w,
                       input logic r, input logic d);
        @(posedge clock_i);
        addr <= a;
        op <= o;
        bsel <= b;
        wdata <= w;
        rd <= r;
        dld <= d;
        @(posedge clock_i);
        op <= GPB_OP_NONE;
        rd <= 1'b0;
        dld <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        cyc(a, GPB_OP_NONE, 3'h0, 8'h00, 1'b1, 1'b0);
        chk(40'(rv), 40'h1);
        chk(40'(rdata), 40'(e));
    endtask

    task automatic complete_run;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_masks;
        // nobody drives: pull-ups make every pin high
        rchk(8'h05, 8'h0f);
        rchk(8'h06, 8'hff);
        rchk(8'h07, 8'hff);
        rchk(8'h08, 8'hff);
        rchk(8'h09, 8'hf0);
        cyc(8'h0a, GPB_OP_NONE, 3'h0, 8'h00, 1'b1, 1'b0);
        chk(40'(rv), 40'h0);
    endtask

    task automatic t_dir_out;
        @(posedge clock_i);
        xen <= '1;
        xval <= '0;
        cyc(8'h06, GPB_OP_WRITE, 3'h0, 8'ha5, 1'b0, 1'b0);
        chk(40'(poe[15:8]), 40'h0);
        cyc(8'h06, GPB_OP_NONE, 3'h0, 8'hf0, 1'b0, 1'b1);
        chk(40'(poe[15:8]), 40'h0f);
        chk(40'(pout[15:8]), 40'ha5);
        rchk(8'h06, 8'h05);
    endtask

    task automatic t_bitop;
        cyc(8'h06, GPB_OP_NONE, 3'h0, 8'hff, 1'b0, 1'b1);
        chk(poe, 40'h0);
        @(posedge clock_i);
        xval <= 40'h8000;
        cyc(8'h06, GPB_OP_BCLR, 3'h0, 8'h00, 1'b0, 1'b0);
        cyc(8'h06, GPB_OP_NONE, 3'h0, 8'h00, 1'b0, 1'b1);
        chk(40'(pout[15:8]), 40'h80);
    endtask

    task automatic t_rst_keep;
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(poe, 40'h0);
        cyc(8'h06, GPB_OP_NONE, 3'h0, 8'h00, 1'b0, 1'b1);
        chk(40'(pout[15:8]), 40'h80);
    endtask

    task automatic t_variant;
        cyc(8'h07, GPB_OP_WRITE, 3'h0, 8'h3c, 1'b0, 1'b0);
        cyc(8'h07, GPB_OP_NONE, 3'h0, 8'h00, 1'b1, 1'b1);
        chk(40'(rv_s), 40'h1);
        chk(40'(rdata_s), 40'h3c);
        chk(40'(poe_s[23:16]), 40'h0);
        chk(40'(rdata), 40'h0);
        cyc(8'h08, GPB_OP_WRITE, 3'h0, 8'h5a, 1'b0, 1'b0);
        cyc(8'h08, GPB_OP_NONE, 3'h0, 8'h00, 1'b1, 1'b0);
        chk(40'(rdata_s), 40'h5a);
        cyc(8'h09, GPB_OP_NONE, 3'h0, 8'h00, 1'b0, 1'b1);
        chk(40'(poe[39:32]), 40'hf0);
        chk(40'(poe_s[39:32]), 40'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // 40 MHz clock, hang guard and main sequence
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (5000) @(posedge clock_i);
        n_fail++;
        complete_run;
    end

    initial
    begin
        {rst_i, rd, dld, addr, wdata, bsel} = {3'b100, 19'h0};
        op = GPB_OP_NONE;
        xval = '0;
        xen = '0;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk(poe | poe_s, 40'h0);
        t_masks;
        t_dir_out;
        t_bitop;
        t_rst_keep;
        t_variant;
        complete_run;
    end
endmodule

`default_nettype wire
